// ---- hw/mapd_port.sv ----
// Command and address front end of a DRAM in multiplexed address mode.
// Assumes command pins synchronous to i_ref_clk; width strap is static.
`timescale 1ns/100ps
// Contract
// - Mode set with bit 5 high switches device into multiplexed mode.
// - Mode set ignores second-half ball 8 and the bank select bits.
// - DLL reset setting turns the delay-locked loop off.
// - Fixed ball mapping of both address halves to address bits.
// - Bits 19 and 20 used only for listed width and burst combinations.
// - Multiplexed mode adds one clock to read and write latency.
// - Configurations 1 to 5 give the tabled row, read, write cycles.
// - Each command executes on the rising edge after its issue edge; a multiplexed-mode auto refresh executes one edge later.
// - Auto refresh has no second half; next command accepted next clock.
// - Two address parts on consecutive clocks, each with own timing.
module mapd_port (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic i_ref_n,
    input wire logic [mapd_pkg::BALL_W-1:0] i_ball,
    input wire logic [mapd_pkg::BANK_W-1:0] i_bank,
    input wire logic [1:0] i_width,
    output logic o_mux_mode,
    output logic o_dll_enable,
    output logic [mapd_pkg::CFG_W-1:0] o_config,
    output logic [1:0] o_burst_len,
    output logic [mapd_pkg::LAT_W-1:0] o_row_cycle,
    output logic [mapd_pkg::LAT_W-1:0] o_read_latency,
    output logic [mapd_pkg::LAT_W-1:0] o_write_latency,
    output logic o_cmd_valid,
    output logic [1:0] o_cmd_kind,
    output logic [mapd_pkg::BANK_W-1:0] o_cmd_bank,
    output logic [mapd_pkg::ADDR_W-1:0] o_cmd_addr
);
    mapd_pkg::mapd_state_e state_r, state_nxt;
    logic [mapd_pkg::BALL_W-1:0] first_half_r;
    logic [mapd_pkg::BANK_W-1:0] bank_r;
    logic [1:0] kind_r;
    logic auto_refresh_cmd_pend_r;
    logic [mapd_pkg::BANK_W-1:0] auto_refresh_cmd_bank_r;
    logic mux_r, dll_en_r;
    logic [mapd_pkg::CFG_W-1:0] cfg_r;
    logic [1:0] bl_r;
    logic [mapd_pkg::LAT_W-1:0] rc_r, rl_r, wl_r;
    logic valid_r;
    logic [1:0] out_kind_r;
    logic [mapd_pkg::BANK_W-1:0] out_bank_r;
    logic [mapd_pkg::ADDR_W-1:0] out_addr_r;
    logic [mapd_pkg::ADDR_W-1:0] mapped_addr;

    // Command decode from the select, write and refresh pins
    wire cmd_sel = !i_cs_n;
    wire [1:0] cmd_code = (!i_we_n && !i_ref_n) ? mapd_pkg::MAPD_CMD_MRS :
                          (!i_we_n) ? mapd_pkg::MAPD_CMD_WRITE :
                          (!i_ref_n) ? mapd_pkg::MAPD_CMD_AUTO_REFRESH_CMD :
                          mapd_pkg::MAPD_CMD_READ;
    wire idle = (state_r == mapd_pkg::MAPD_ST_IDLE);
    wire half2 = (state_r == mapd_pkg::MAPD_ST_HALF2);
    wire take_cmd = idle && cmd_sel;
    wire mux_auto_refresh_cmd = take_cmd && mux_r &&
                    (cmd_code == mapd_pkg::MAPD_CMD_AUTO_REFRESH_CMD);
    wire mux_two = take_cmd && mux_r && !mux_auto_refresh_cmd;
    wire flat_exec = take_cmd && !mux_r;

    mapd_addr_map u_map (
        .i_first_half(first_half_r),
        .i_second_half(i_ball),
        .i_width(i_width),
        .i_burst_len(bl_r),
        .o_addr(mapped_addr)
    );

    // Mode register load, two-cycle form in multiplexed mode
    wire mrs_mux = half2 && (kind_r == mapd_pkg::MAPD_CMD_MRS);
    wire mrs_flat = flat_exec && (cmd_code == mapd_pkg::MAPD_CMD_MRS);
    wire mrs_fire = mrs_mux || mrs_flat;
    wire [mapd_pkg::ADDR_W-1:0] flat_addr = {3'h0, i_ball};
    wire [mapd_pkg::ADDR_W-1:0] mrs_addr = mrs_mux ?
        (mapped_addr & ~(22'h1 << mapd_pkg::MR_IGNORED_BIT)) :
        flat_addr;
    wire [mapd_pkg::CFG_W-1:0] cfg_new =
        mrs_addr[mapd_pkg::MR_CFG_LSB +: mapd_pkg::CFG_W];
    wire [1:0] bl_new = mrs_addr[mapd_pkg::MR_BL_LSB +: 2];
    wire mux_new = mrs_addr[mapd_pkg::MR_MUX_BIT];
    wire dll_en_new = !mrs_addr[mapd_pkg::MR_DLL_RST_BIT];

    // Configuration table lookup
    wire cfg_bad = (cfg_new == 3'h0) || (cfg_new > 3'h5);
    wire [2:0] cfg_idx = cfg_bad ? 3'h0 : (cfg_new - 3'h1);
    wire [mapd_pkg::LAT_W-1:0] rc_new = mapd_pkg::RC_TAB[cfg_idx];
    wire [mapd_pkg::LAT_W-1:0] lat_adj =
        mux_new ? 4'h0 : mapd_pkg::MUX_EXTRA;
    wire [mapd_pkg::LAT_W-1:0] rl_new =
        mapd_pkg::RL_TAB[cfg_idx] - lat_adj;
    wire [mapd_pkg::LAT_W-1:0] wl_new =
        mapd_pkg::WL_TAB[cfg_idx] - lat_adj;

    // Execute selection for the output stage
    wire exec_now = half2 || auto_refresh_cmd_pend_r || flat_exec;
    wire [1:0] exec_kind = half2 ? kind_r :
                           auto_refresh_cmd_pend_r ? mapd_pkg::MAPD_CMD_AUTO_REFRESH_CMD : cmd_code;
    wire [mapd_pkg::BANK_W-1:0] exec_bank_raw = half2 ? bank_r :
                                   auto_refresh_cmd_pend_r ? auto_refresh_cmd_bank_r : i_bank;
    wire [mapd_pkg::BANK_W-1:0] exec_bank =
        (exec_kind == mapd_pkg::MAPD_CMD_MRS) ? 3'h0 : exec_bank_raw;
    wire [mapd_pkg::ADDR_W-1:0] exec_addr = mrs_mux ? mrs_addr :
                                   half2 ? mapped_addr :
                                   auto_refresh_cmd_pend_r ? 22'h0 : flat_addr;

    always_comb begin
        case (state_r)
            mapd_pkg::MAPD_ST_IDLE: begin
                state_nxt = mux_two ? mapd_pkg::MAPD_ST_HALF2 :
                            mapd_pkg::MAPD_ST_IDLE;
            end
            mapd_pkg::MAPD_ST_HALF2: begin
                state_nxt = mapd_pkg::MAPD_ST_IDLE;
            end
            default: begin
                state_nxt = mapd_pkg::MAPD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= mapd_pkg::MAPD_ST_IDLE;
            first_half_r <= '0;
            bank_r <= '0;
            kind_r <= 2'h0;
            auto_refresh_cmd_pend_r <= 1'b0;
            auto_refresh_cmd_bank_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (mux_two) begin
                first_half_r <= i_ball;
                bank_r <= i_bank;
                kind_r <= cmd_code;
            end
            auto_refresh_cmd_pend_r <= mux_auto_refresh_cmd;
            if (mux_auto_refresh_cmd) begin
                auto_refresh_cmd_bank_r <= i_bank;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mux_r <= mapd_pkg::MUX_RST;
            dll_en_r <= mapd_pkg::DLL_EN_RST;
            cfg_r <= mapd_pkg::CFG_RST;
            bl_r <= mapd_pkg::BL_RST;
            rc_r <= mapd_pkg::RC_TAB[0];
            rl_r <= mapd_pkg::RL_TAB[0] - mapd_pkg::MUX_EXTRA;
            wl_r <= mapd_pkg::WL_TAB[0] - mapd_pkg::MUX_EXTRA;
        end else if (mrs_fire) begin
            mux_r <= mux_new;
            dll_en_r <= dll_en_new;
            cfg_r <= cfg_new;
            bl_r <= bl_new;
            rc_r <= rc_new;
            rl_r <= rl_new;
            wl_r <= wl_new;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            valid_r <= 1'b0;
            out_kind_r <= 2'h0;
            out_bank_r <= '0;
            out_addr_r <= '0;
        end else begin
            valid_r <= exec_now;
            if (exec_now) begin
                out_kind_r <= exec_kind;
                out_bank_r <= exec_bank;
                out_addr_r <= exec_addr;
            end
        end
    end

    assign o_mux_mode = mux_r;
    assign o_dll_enable = dll_en_r;
    assign o_config = cfg_r;
    assign o_burst_len = bl_r;
    assign o_row_cycle = rc_r;
    assign o_read_latency = rl_r;
    assign o_write_latency = wl_r;
    assign o_cmd_valid = valid_r;
    assign o_cmd_kind = out_kind_r;
    assign o_cmd_bank = out_bank_r;
    assign o_cmd_addr = out_addr_r;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    chk_mux_enter: assert property (
        mrs_fire && mrs_addr[mapd_pkg::MR_MUX_BIT] |=> o_mux_mode)
        else $error("mode set with bit 5 did not enter mux mode");
    chk_dll_off: assert property (
        mrs_fire && mrs_addr[mapd_pkg::MR_DLL_RST_BIT] |=> !o_dll_enable)
        else $error("DLL reset setting left DLL enabled");
    chk_mrs_bank: assert property (
        o_cmd_valid && o_cmd_kind == mapd_pkg::MAPD_CMD_MRS |->
        o_cmd_bank == 3'h0)
        else $error("bank bits not ignored on mode set");
    chk_mux_latency: assert property (
        o_mux_mode |-> o_read_latency == o_row_cycle + 4'h1)
        else $error("mux mode read latency not row cycle plus one");
    chk_flat_latency: assert property (
        !o_mux_mode |-> o_read_latency == o_row_cycle)
        else $error("flat mode read latency wrong");
    chk_wl_above_rl: assert property (
        o_write_latency == o_read_latency + 4'h1)
        else $error("write latency not read latency plus one");
    chk_two_cycle: assert property (
        mux_two ##1 half2 |=> o_cmd_valid && o_cmd_kind == $past(kind_r))
        else $error("two-cycle command not executed on next edge");
    chk_auto_refresh_cmd_next: assert property (
        mux_auto_refresh_cmd |=> idle && auto_refresh_cmd_pend_r
        ##1 o_cmd_valid && o_cmd_kind == mapd_pkg::MAPD_CMD_AUTO_REFRESH_CMD)
        else $error("auto refresh took a second half");
    chk_half_order: assert property (
        half2 |=> idle && o_cmd_addr[1] == $past(i_ball[3]) &&
        o_cmd_addr[0] == $past(first_half_r[0]))
        else $error("second half not captured on following edge");
    chk_a19_drop: assert property (
        half2 && i_width == mapd_pkg::W_X36 && bl_r != mapd_pkg::BL_2 |=>
        !o_cmd_addr[19])
        else $error("bit 19 used for x36 long burst");
    chk_a21_only: assert property (
        half2 && !(i_width == mapd_pkg::W_X9 && bl_r == mapd_pkg::BL_2) |=>
        !o_cmd_addr[21])
        else $error("bit 21 used outside x9 burst 2");

    cov_enter_mux: cover property (mrs_flat && mux_new ##1 o_mux_mode);
    cov_mux_read: cover property (
        mux_two && cmd_code == mapd_pkg::MAPD_CMD_READ ##2 o_cmd_valid);
    cov_auto_refresh_cmd_then_cmd: cover property (mux_auto_refresh_cmd ##1 mux_two);
    cov_mux_mrs: cover property (mrs_mux);
endmodule

// ---- hw/mapd_pkg.sv ----
// Shared constants for the multiplexed-address command port.
// Assumes a single 100 MHz clock domain and plain-port configuration.
package mapd_pkg;
    localparam int BALL_W = 19;
    localparam int ADDR_W = 22;
    localparam int BANK_W = 3;
    localparam int LAT_W = 4;
    localparam int CFG_W = 3;

    // Clock
    localparam real CLK_PERIOD_NS = 10.0;

    // Mode register field positions in the assembled address
    localparam int MR_CFG_LSB = 0;
    localparam int MR_BL_LSB = 3;
    localparam int MR_MUX_BIT = 5;
    localparam int MR_IGNORED_BIT = 6;
    localparam int MR_DLL_RST_BIT = 7;

    // Reset values
    localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
    localparam logic [1:0] BL_RST = 2'h0;
    localparam logic MUX_RST = 1'h0;
    localparam logic DLL_EN_RST = 1'h0;

    // Data width straps
    localparam logic [1:0] W_X9 = 2'h0;
    localparam logic [1:0] W_X18 = 2'h1;
    localparam logic [1:0] W_X36 = 2'h2;

    // Burst length settings
    localparam logic [1:0] BL_2 = 2'h0;
    localparam logic [1:0] BL_4 = 2'h1;
    localparam logic [1:0] BL_8 = 2'h2;

    // Configuration tables, multiplexed mode, configurations 1 to 5
    localparam int NUM_CFG = 5;
    localparam logic [LAT_W-1:0] RC_TAB [0:NUM_CFG-1] =
        '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    localparam logic [LAT_W-1:0] RL_TAB [0:NUM_CFG-1] =
        '{4'h5, 4'h7, 4'h9, 4'h4, 4'h6};
    localparam logic [LAT_W-1:0] WL_TAB [0:NUM_CFG-1] =
        '{4'h6, 4'h8, 4'ha, 4'h5, 4'h7};
    localparam logic [LAT_W-1:0] MUX_EXTRA = 4'h1;

    typedef enum logic [1:0] {
        MAPD_CMD_READ = 2'h0,
        MAPD_CMD_WRITE = 2'h1,
        MAPD_CMD_AUTO_REFRESH_CMD = 2'h2,
        MAPD_CMD_MRS = 2'h3
    } mapd_cmd_e;

    typedef enum logic {
        MAPD_ST_IDLE = 1'b0,
        MAPD_ST_HALF2 = 1'b1
    } mapd_state_e;
endpackage

// ---- hw/mapd_addr_map.sv ----
// Ball-to-address mapping for the two halves of a multiplexed command.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module mapd_addr_map (
    input wire logic [mapd_pkg::BALL_W-1:0] i_first_half,
    input wire logic [mapd_pkg::BALL_W-1:0] i_second_half,
    input wire logic [1:0] i_width,
    input wire logic [1:0] i_burst_len,
    output logic [mapd_pkg::ADDR_W-1:0] o_addr
);
    wire is_x9 = (i_width == mapd_pkg::W_X9);
    wire is_x18 = (i_width == mapd_pkg::W_X18);
    wire is_x36 = (i_width == mapd_pkg::W_X36);
    wire bl2 = (i_burst_len == mapd_pkg::BL_2);
    wire bl4 = (i_burst_len == mapd_pkg::BL_4);
    wire bl8 = (i_burst_len == mapd_pkg::BL_8);
    wire use_a19 = !((is_x36 && (bl4 || bl8)) ||
                     (is_x18 && bl8));
    wire use_a20 = (is_x18 && bl2) || (is_x9 && (bl2 || bl4));
    wire use_a21 = is_x9 && bl2;
    wire use_a18 = !(is_x36 && bl8);

    // First half carries like-numbered bits
    assign o_addr[0] = i_first_half[0];
    assign o_addr[3] = i_first_half[3];
    assign o_addr[4] = i_first_half[4];
    assign o_addr[5] = i_first_half[5];
    assign o_addr[8] = i_first_half[8];
    assign o_addr[9] = i_first_half[9];
    assign o_addr[10] = i_first_half[10];
    assign o_addr[13] = i_first_half[13];
    assign o_addr[14] = i_first_half[14];
    assign o_addr[17] = i_first_half[17];
    assign o_addr[18] = use_a18 & i_first_half[18];
    // Second half carries the remaining bits
    assign o_addr[1] = i_second_half[3];
    assign o_addr[2] = i_second_half[4];
    assign o_addr[6] = i_second_half[8];
    assign o_addr[7] = i_second_half[9];
    assign o_addr[11] = i_second_half[13];
    assign o_addr[12] = i_second_half[14];
    assign o_addr[16] = i_second_half[17];
    assign o_addr[15] = i_second_half[18];
    assign o_addr[19] = use_a19 & i_second_half[10];
    assign o_addr[20] = use_a20 & i_second_half[0];
    assign o_addr[21] = use_a21 & i_second_half[5];
endmodule

// ---- tb/mapd_ctrl_model.sv ----
// Memory controller model driving the command pins of the port.
// Assumes the bench calls its tasks; pins move on the falling edge.
`timescale 1ns/100ps
module mapd_ctrl_model #(
    parameter int SETTLE_CYC = 8
) (
    input wire logic i_ref_clk,
    input wire logic [mapd_pkg::LAT_W-1:0] i_row_cycle,
    output logic o_cs_n,
    output logic o_we_n,
    output logic o_ref_n,
    output logic [mapd_pkg::BALL_W-1:0] o_ball,
    output logic [mapd_pkg::BANK_W-1:0] o_bank
);
    localparam logic [1:0] K_RD = mapd_pkg::MAPD_CMD_READ;
    localparam logic [1:0] K_WR = mapd_pkg::MAPD_CMD_WRITE;
    localparam logic [1:0] K_AUTO_REFRESH_CMD = mapd_pkg::MAPD_CMD_AUTO_REFRESH_CMD;
    localparam logic [1:0] K_MRS = mapd_pkg::MAPD_CMD_MRS;
    int cyc = 0;
    int last_use [0:7] = '{default: -100};
    logic [1:0] last_kind [0:7] = '{default: 2'h0};
    int iss_q [$];
    initial begin
        o_cs_n = 1'b1;
        o_we_n = 1'b1;
        o_ref_n = 1'b1;
        o_ball = 19'h0;
        o_bank = 3'h0;
    end
    always @(posedge i_ref_clk) cyc <= cyc + 1;
    // Released ball and bank pins show the inverse of the last value; chip select goes high
    task automatic release_pins();
        @(negedge i_ref_clk);
        o_cs_n = 1'b1;
        o_ball = ~o_ball;
        o_bank = ~o_bank;
    endtask
    task automatic issue(input logic [1:0] kind, input logic [2:0] bank,
            input logic [18:0] f, input logic [18:0] s, input bit mux);
        int gap;
        gap = int'(i_row_cycle);
        if (gap == 3 && last_kind[bank] == K_WR && kind == K_RD) begin
            gap = 4;
        end
        @(negedge i_ref_clk);
        while (kind != K_MRS && cyc - last_use[bank] < gap) begin
            o_cs_n = 1'b1;
            @(negedge i_ref_clk);
        end
        o_cs_n = 1'b0;
        o_we_n = !(kind == K_WR || kind == K_MRS);
        o_ref_n = !(kind == K_AUTO_REFRESH_CMD || kind == K_MRS);
        o_ball = f;
        o_bank = bank;
        iss_q.push_back(cyc);
        if (kind != K_MRS) begin
            last_use[bank] = cyc;
            last_kind[bank] = kind;
        end
        if (mux && kind != K_AUTO_REFRESH_CMD) begin
            @(negedge i_ref_clk);
            o_cs_n = 1'b1;
            o_ball = s;
        end
        if (kind == K_MRS) begin
            release_pins();
            repeat (SETTLE_CYC) @(negedge i_ref_clk);
        end
    endtask
endmodule

// ---- tb/mapd_port_test.sv ----
// Self-checking bench for the multiplexed-address command port.
// Assumes the controller model drives every command pin.
`timescale 1ns/100ps
module mapd_port_test;
    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] bank;
        logic [21:0] addr;
        logic [31:0] cyc;
    } mapd_mon_s;
    localparam logic [1:0] K_RD = mapd_pkg::MAPD_CMD_READ;
    localparam logic [1:0] K_WR = mapd_pkg::MAPD_CMD_WRITE;
    localparam logic [1:0] K_AUTO_REFRESH_CMD = mapd_pkg::MAPD_CMD_AUTO_REFRESH_CMD;
    localparam logic [1:0] K_MRS = mapd_pkg::MAPD_CMD_MRS;
    localparam logic [18:0] F = 19'h2b6d5;
    localparam logic [18:0] S = 19'h56ab3;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] width = 2'h2;
    logic cs_n, we_n, ref_n, mux_mode, dll_en, cmd_valid;
    logic [18:0] ball;
    logic [2:0] bank, config_v, cmd_bank;
    logic [1:0] bl, cmd_kind;
    logic [3:0] rc, rl, wl;
    logic [21:0] cmd_addr;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int rc_t [0:4] = '{4, 6, 8, 3, 5};
    int rl_t [0:4] = '{5, 7, 9, 4, 6};
    int wl_t [0:4] = '{6, 8, 10, 5, 7};
    mapd_mon_s mon_q [$];
    always #5 i_ref_clk = ~i_ref_clk;
    mapd_ctrl_model PARTNER (.i_ref_clk(i_ref_clk), .i_row_cycle(rc),
        .o_cs_n(cs_n), .o_we_n(we_n), .o_ref_n(ref_n), .o_ball(ball),
        .o_bank(bank));
    mapd_port DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n),
        .i_we_n(we_n), .i_ref_n(ref_n), .i_ball(ball), .i_bank(bank),
        .i_width(width), .o_mux_mode(mux_mode), .o_dll_enable(dll_en),
        .o_config(config_v), .o_burst_len(bl), .o_row_cycle(rc),
        .o_read_latency(rl), .o_write_latency(wl), .o_cmd_valid(cmd_valid),
        .o_cmd_kind(cmd_kind), .o_cmd_bank(cmd_bank), .o_cmd_addr(cmd_addr));
    always @(posedge i_ref_clk) cyc <= cyc + 1;
    always @(negedge i_ref_clk) begin
        if (cmd_valid === 1'b1) begin
            mon_q.push_back('{cmd_kind, cmd_bank, cmd_addr, cyc});
        end
    end
    always @(posedge i_ref_clk) begin
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic expect_cmd(input logic [1:0] kind, input logic [2:0] bnk,
            input logic [21:0] addr, input int lat);
        mapd_mon_s e;
        int t0;
        if (mon_q.size() == 0 || PARTNER.iss_q.size() == 0) begin
            chk("cmd_seen", 32'h1, 32'h0);
        end else begin
            e = mon_q.pop_front();
            t0 = PARTNER.iss_q.pop_front();
            chk("cmd_kind", kind, e.kind);
            chk("cmd_bank", bnk, e.bank);
            chk("cmd_addr", addr, e.addr);
            chk("cmd_cycle", t0 + lat, e.cyc);
        end
    endtask
    function automatic logic [21:0] exp_addr(input logic [18:0] f,
            input logic [18:0] s, input logic [1:0] w, input logic [1:0] b);
        logic [21:0] a;
        logic x36, x9;
        x36 = (w == mapd_pkg::W_X36);
        x9 = (w == mapd_pkg::W_X9);
        a = {3'h0, f & 19'h66739};
        if (x36 && b == mapd_pkg::BL_8) a[18] = 1'b0;
        a[2:1] = s[4:3];
        a[7:6] = s[9:8];
        a[12:11] = s[14:13];
        a[15] = s[18];
        a[16] = s[17];
        a[19] = s[10] & !(x36 ? b != mapd_pkg::BL_2 :
            !x9 && b == mapd_pkg::BL_8);
        a[20] = s[0] & (x9 ? b != mapd_pkg::BL_8 : !x36 && b == 2'h0);
        a[21] = s[5] & x9 & (b == mapd_pkg::BL_2);
        return a;
    endfunction
    // Two-cycle mode set; high bits low, second-half ball 8 set
    task automatic mode_set(input logic [2:0] c, input logic [1:0] b,
            input logic d, input logic m);
        PARTNER.issue(K_MRS, 3'h5, {13'h0, m, b, 2'h0, c[0]},
            {9'h0, d, 1'b1, 3'h0, c[2:1], 3'h0}, 1'b1);
        expect_cmd(K_MRS, 3'h0, {14'h0, d, 1'b0, m, b, c}, 2);
    endtask
    task automatic t_reset();
        chk("mux_mode", 32'h0, mux_mode);
        chk("dll_en", 32'h0, dll_en);
        chk("row_cycle", 32'h4, rc);
        chk("read_lat", 32'h4, rl);
        chk("write_lat", 32'h5, wl);
        chk("cmd_valid", 32'h0, cmd_valid);
    endtask
    task automatic t_init();
        PARTNER.issue(K_MRS, 3'h0, 19'h0, 19'h0, 1'b0);
        expect_cmd(K_MRS, 3'h0, 22'h0, 1);
        PARTNER.issue(K_MRS, 3'h6, 19'h20, 19'h0, 1'b0);
        expect_cmd(K_MRS, 3'h0, 22'h20, 1);
        chk("mux_mode", 32'h1, mux_mode);
        chk("row_cycle", 32'h4, rc);
        chk("read_lat", 32'h5, rl);
        chk("write_lat", 32'h6, wl);
        for (int i = 0; i < 8; i++) begin
            PARTNER.issue(K_AUTO_REFRESH_CMD, 3'(i), 19'h0, 19'h0, 1'b1);
        end
        repeat (1024) PARTNER.release_pins();
        for (int i = 0; i < 8; i++) begin
            expect_cmd(K_AUTO_REFRESH_CMD, 3'(i), 22'h0, 2);
        end
        chk("extra_cmd", 32'h0, mon_q.size());
    endtask
    task automatic t_configs();
        for (int k = 1; k <= 5; k++) begin
            mode_set(3'(k), mapd_pkg::BL_4, 1'b0, 1'b1);
            chk("config", k, config_v);
            chk("row_cycle", rc_t[k-1], rc);
            chk("read_lat", rl_t[k-1], rl);
            chk("write_lat", wl_t[k-1], wl);
            chk("dll_en", 32'h1, dll_en);
        end
        mode_set(3'h2, mapd_pkg::BL_4, 1'b1, 1'b1);
        chk("dll_en", 32'h0, dll_en);
    endtask
    task automatic t_map();
        for (int w = 0; w < 3; w++) begin
            for (int b = 0; b < 3; b++) begin
                width = 2'(w);
                mode_set(3'h2, 2'(b), 1'b0, 1'b1);
                PARTNER.issue(K_WR, 3'(w + b), F, S, 1'b1);
                PARTNER.issue(K_RD, 3'(w + b + 1), ~F, ~S, 1'b1);
                repeat (3) PARTNER.release_pins();
                expect_cmd(K_WR, 3'(w + b), exp_addr(F, S, width, 2'(b)),
                    2);
                expect_cmd(K_RD, 3'(w + b + 1),
                    exp_addr(~F, ~S, width, 2'(b)),
                    2);
            end
        end
    endtask
    task automatic t_b2b();
        PARTNER.issue(K_AUTO_REFRESH_CMD, 3'h1, 19'h0, 19'h0, 1'b1);
        PARTNER.issue(K_RD, 3'h2, F, S, 1'b1);
        PARTNER.issue(K_WR, 3'h1, ~F, ~S, 1'b1);
        repeat (3) PARTNER.release_pins();
        expect_cmd(K_AUTO_REFRESH_CMD, 3'h1, 22'h0, 2);
        expect_cmd(K_RD, 3'h2, exp_addr(F, S, 2'h2, 2'h2), 2);
        expect_cmd(K_WR, 3'h1, exp_addr(~F, ~S, 2'h2, 2'h2), 2);
    endtask
    task automatic t_leave();
        mode_set(3'h3, mapd_pkg::BL_2, 1'b0, 1'b0);
        chk("mux_mode", 32'h0, mux_mode);
        chk("row_cycle", 32'h8, rc);
        chk("read_lat", 32'h8, rl);
        chk("write_lat", 32'h9, wl);
        PARTNER.issue(K_RD, 3'h4, F, S, 1'b0);
        repeat (3) PARTNER.release_pins();
        expect_cmd(K_RD, 3'h4, {3'h0, F}, 1);
        chk("extra_cmd", 32'h0, mon_q.size());
    endtask
    initial begin
        repeat (5) @(negedge i_ref_clk);
        t_reset();
        i_rst = 1'b0;
        t_init();
        t_configs();
        t_map();
        t_b2b();
        t_leave();
        conclude();
    end
endmodule
